// >>> inc/flsw_pkg.sv
/*
  Shared constants and types of the flash status and write-protect block:
  status bit layout, power-up value, command codes, protection bounds,
  bus register offsets, interrupt bits, op kinds, timing and FSM states.
  Assumes a 20-bit byte address space for the array.
*/
package flsw_pkg;
  // status register layout
  localparam int STAT_BUSY = 0;
  localparam int STAT_WEL = 1;
  localparam int STAT_BP_LSB = 2;
  localparam int STAT_BP_MSB = 5;
  localparam int STAT_AAI = 6;
  localparam int STAT_LOCK = 7;
  localparam logic [3:0] BP_RESET = 4'h7;
  localparam logic [3:0] BP_NONE = 4'h0;

  // command codes, values arbitrary
  localparam logic [7:0] OPC_READ_STATUS = 8'h01;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h02;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h03;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h04;
  localparam logic [7:0] OPC_BYTE_PROG = 8'h05;
  localparam logic [7:0] OPC_AUTO_INC = 8'h06;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h07;
  localparam logic [7:0] OPC_BLOCK_ERASE = 8'h08;
  localparam logic [7:0] OPC_CHIP_ERASE = 8'h09;

  // array addressing and protected-range lower bounds
  localparam int ADDR_W = 20;
  localparam logic [ADDR_W:0] PROT_BASE_NONE = 21'h100000;
  localparam logic [ADDR_W:0] PROT_BASE_1 = 21'h0f0000;
  localparam logic [ADDR_W:0] PROT_BASE_2 = 21'h0e0000;
  localparam logic [ADDR_W:0] PROT_BASE_3 = 21'h0c0000;
  localparam logic [ADDR_W:0] PROT_BASE_4 = 21'h080000;
  localparam logic [ADDR_W:0] PROT_BASE_ALL = 21'h000000;
  localparam logic [ADDR_W-1:0] SECTOR_MASK = 20'hff000;
  localparam logic [ADDR_W-1:0] BLOCK_MASK = 20'hf0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 20'h00001;
  localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // array operation kinds
  localparam logic [1:0] OPK_PROGRAM = 2'h0;
  localparam logic [1:0] OPK_SECTOR = 2'h1;
  localparam logic [1:0] OPK_BLOCK = 2'h2;
  localparam logic [1:0] OPK_CHIP = 2'h3;

  // timing, values arbitrary
  localparam int REF_CLK_MHZ = 20;
  localparam int PROG_TIME_US = 10;
  localparam int SECTOR_TIME_MS = 25;
  localparam int BLOCK_TIME_MS = 25;
  localparam int CHIP_TIME_MS = 50;
  localparam int BUSY_CNT_W = 24;

  // AHB-Lite slave
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam int IRQ_W = 3;
  localparam int IRQ_OP_DONE = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_WS_REFUSED = 2;
  localparam int WP_VIEW_POS = 8;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_CMD = 7'b0000010,
    ST_ADDR = 7'b0000100,
    ST_DATA = 7'b0001000,
    ST_STATUS = 7'b0010000,
    ST_DONE = 7'b0100000,
    ST_IGNORE = 7'b1000000
  } flsw_state_t;
endpackage : flsw_pkg

// >>> logic/flsw_spi_rx.sv
/*
  Serial front end: synchronises chip select, serial clock and data in,
  finds serial clock edges, assembles bytes MSB first and shifts a reply
  byte out after each falling edge.
  Assumes the serial clock is several REF_CLK periods long in each phase.
*/
`timescale 1ns/1ps
module flsw_spi_rx
  import flsw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic [7:0] tx_byte,
  input wire logic tx_en,
  output logic frame_start,
  output logic frame_end,
  output logic byte_valid,
  output logic [7:0] rx_byte,
  output logic so,
  output logic so_oe
);
  logic ce_s1, ce_s2, ce_q;
  logic sck_s1, sck_s2, sck_q;
  logic si_s1, si_s2;
  logic [2:0] bit_cnt;
  logic [6:0] shreg;
  logic [7:0] tx_sh;
  logic sck_rise, sck_fall;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ce_s1 <= 1'b1;
      ce_s2 <= 1'b1;
      ce_q <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_q <= 1'b0;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
    end else begin
      ce_s1 <= ce_n_pin;
      ce_s2 <= ce_s1;
      ce_q <= ce_s2;
      sck_s1 <= sck_pin;
      sck_s2 <= sck_s1;
      sck_q <= sck_s2;
      si_s1 <= si_pin;
      si_s2 <= si_s1;
    end
  end

  // edges outside a frame are dropped, so mode 3 idle-high clocks are safe
  assign sck_rise = sck_s2 & ~sck_q & ~ce_s2;
  assign sck_fall = ~sck_s2 & sck_q & ~ce_s2;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_start <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      frame_start <= ce_q & ~ce_s2;
      frame_end <= ~ce_q & ce_s2;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 3'h0;
      shreg <= 7'h00;
      byte_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      if (ce_s2) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        shreg <= {shreg[5:0], si_s2};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == BIT_LAST) begin
          byte_valid <= 1'b1;
          rx_byte <= {shreg, si_s2};
        end
      end
    end
  end

  // reply reloaded at every byte boundary so polling sees fresh status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_sh <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_oe <= tx_en & ~ce_s2;
      if (sck_rise && bit_cnt == BIT_LAST) begin
        tx_sh <= tx_byte;
      end else if (sck_fall) begin
        so <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end
endmodule : flsw_spi_rx

// >>> logic/flsw_top.sv
/*
  Status register and write-protect logic of a serial flash: serial
  command decode for status, enable and program/erase commands, busy
  timer, protection checks, AHB-Lite register view and interrupt.
  Assumes the array engine takes OP_START with kind, address and data and
  needs no handshake back; busy time is timed here.
*/
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
// Functional notes
// - status bit 0 reads 1 during program or erase, else 0; reset 0.
// - while busy, only status read is serviced; other commands ignored.
// - bit 1 is write enable latch, reset 0; program/erase refused when 0.
// - latch cleared on disable, program, erase and executed status write.
// - latch cleared when auto-increment ends or hits top unprotected address.
// - bit 6 shows auto-increment mode, 0 in byte-program mode at reset.
// - bits 2 to 4 select the protected array region; bit 5 only blocks chip erase.
// - protection bits reset to 0111, array protected by default.
// - status write changes protection only if protect pin high or lock 0.
// - bit 7 lock with pin low freezes lock and protection bits.
// - lock bit resets to 0.
// - chip erase runs only when all four protection bits are 0.
// - status write refused when pin low and lock 1, else executed.
module flsw_top
  import flsw_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_TIME_US * REF_CLK_MHZ,
  parameter int SECTOR_CYCLES = SECTOR_TIME_MS * 1000 * REF_CLK_MHZ,
  parameter int BLOCK_CYCLES = BLOCK_TIME_MS * 1000 * REF_CLK_MHZ,
  parameter int CHIP_CYCLES = CHIP_TIME_MS * 1000 * REF_CLK_MHZ
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic SPI_CE_N,
  input wire logic SPI_SCK,
  input wire logic SPI_SI,
  output logic SPI_SO,
  output logic SPI_SO_OE,
  input wire logic WP_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic IRQ,
  output logic OP_START,
  output logic [1:0] OP_KIND,
  output logic [flsw_pkg::ADDR_W-1:0] OP_ADDR,
  output logic [7:0] OP_DATA
);
  import flsw_pkg::*;

  logic wp_s1, wp_s2;
  logic frame_start, frame_end, byte_valid;
  logic [7:0] rx_byte;
  logic [7:0] status;
  logic busy, write_enable_latch, auto_increment_program, lock;
  logic [3:0] bp;
  flsw_state_t state;
  logic [7:0] opcode, data;
  logic [ADDR_W-1:0] addr, aai_addr;
  logic [1:0] addr_idx;
  logic [BUSY_CNT_W-1:0] busy_cnt;
  logic op_done, op_in_aai, aai_last;
  logic exec, do_wren, do_write_disable_cmd, ws_ok, ws_refused, do_start, reject, aai_first;
  logic [1:0] st_kind;
  logic [ADDR_W-1:0] st_addr;
  logic [IRQ_W-1:0] irq_stat, irq_mask, irq_set, irq_clr;
  logic ahb_wr, ahb_rd_ok;
  logic [7:0] ahb_addr;

  // lowest protected address; none gives one past the top
  function automatic logic [ADDR_W:0] prot_base(input logic [3:0] lvl);
    case (lvl[2:0])
      3'h0: prot_base = PROT_BASE_NONE;
      3'h1: prot_base = PROT_BASE_1;
      3'h2: prot_base = PROT_BASE_2;
      3'h3: prot_base = PROT_BASE_3;
      3'h4: prot_base = PROT_BASE_4;
      default: prot_base = PROT_BASE_ALL;
    endcase
  endfunction : prot_base

  function automatic logic is_prot(input logic [3:0] lvl, input logic [ADDR_W-1:0] a);
    is_prot = {1'b0, a} >= prot_base(lvl);
  endfunction : is_prot

  function automatic flsw_state_t cmd_route(input logic [7:0] op, input logic bsy,
                                            input logic inc);
    if (bsy && op != OPC_READ_STATUS) begin
      cmd_route = ST_IGNORE;
    end else if (inc && op != OPC_READ_STATUS && op != OPC_AUTO_INC &&
                 op != OPC_WRITE_DISABLE) begin
      cmd_route = ST_IGNORE;
    end else begin
      case (op)
        OPC_READ_STATUS: cmd_route = ST_STATUS;
        OPC_WRITE_ENABLE: cmd_route = ST_DONE;
        OPC_WRITE_DISABLE: cmd_route = ST_DONE;
        OPC_CHIP_ERASE: cmd_route = ST_DONE;
        OPC_WRITE_STATUS: cmd_route = ST_DATA;
        OPC_BYTE_PROG: cmd_route = ST_ADDR;
        OPC_SECTOR_ERASE: cmd_route = ST_ADDR;
        OPC_BLOCK_ERASE: cmd_route = ST_ADDR;
        OPC_AUTO_INC: cmd_route = inc ? ST_DATA : ST_ADDR;
        default: cmd_route = ST_IGNORE;
      endcase
    end
  endfunction : cmd_route

  function automatic logic [BUSY_CNT_W-1:0] busy_load(input logic [1:0] kind);
    case (kind)
      OPK_PROGRAM: busy_load = BUSY_CNT_W'(PROG_CYCLES - 1);
      OPK_SECTOR: busy_load = BUSY_CNT_W'(SECTOR_CYCLES - 1);
      OPK_BLOCK: busy_load = BUSY_CNT_W'(BLOCK_CYCLES - 1);
      default: busy_load = BUSY_CNT_W'(CHIP_CYCLES - 1);
    endcase
  endfunction : busy_load

  flsw_spi_rx u_spi (
    .clk(REF_CLK),
    .nrst(NRST),
    .ce_n_pin(SPI_CE_N),
    .sck_pin(SPI_SCK),
    .si_pin(SPI_SI),
    .tx_byte(status),
    .tx_en(state == ST_STATUS),
    .frame_start(frame_start),
    .frame_end(frame_end),
    .byte_valid(byte_valid),
    .rx_byte(rx_byte),
    .so(SPI_SO),
    .so_oe(SPI_SO_OE)
  );

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
    end else begin
      wp_s1 <= WP_N;
      wp_s2 <= wp_s1;
    end
  end

  assign status = {lock, auto_increment_program, bp, write_enable_latch, busy};

  // command byte sequencing
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_IDLE;
      opcode <= 8'h00;
      data <= 8'h00;
      addr <= ADDR_ZERO;
      addr_idx <= 2'h0;
    end else if (frame_start) begin
      state <= ST_CMD;
      addr_idx <= 2'h0;
    end else if (frame_end) begin
      state <= ST_IDLE;
    end else if (byte_valid) begin
      case (state)
        ST_CMD: begin
          opcode <= rx_byte;
          state <= cmd_route(rx_byte, busy, auto_increment_program);
        end
        ST_ADDR: begin
          addr <= {addr[ADDR_W-9:0], rx_byte};
          addr_idx <= addr_idx + 2'h1;
          if (addr_idx == ADDR_BYTE_LAST) begin
            state <= (opcode == OPC_BYTE_PROG || opcode == OPC_AUTO_INC) ? ST_DATA : ST_DONE;
          end
        end
        ST_DATA: begin
          data <= rx_byte;
          state <= ST_DONE;
        end
        default: state <= state;
      endcase
    end
  end

  // commands act when chip select rises after a complete sequence
  always_comb begin
    exec = frame_end && state == ST_DONE;
    do_wren = 1'b0;
    do_write_disable_cmd = 1'b0;
    ws_ok = 1'b0;
    ws_refused = 1'b0;
    do_start = 1'b0;
    reject = 1'b0;
    aai_first = 1'b0;
    st_kind = OPK_PROGRAM;
    st_addr = addr;
    if (exec) begin
      case (opcode)
        OPC_WRITE_ENABLE: do_wren = 1'b1;
        OPC_WRITE_DISABLE: do_write_disable_cmd = 1'b1;
        OPC_WRITE_STATUS: begin
          ws_ok = wp_s2 | ~lock;
          ws_refused = ~wp_s2 & lock;
        end
        OPC_BYTE_PROG: begin
          do_start = write_enable_latch & ~is_prot(bp, addr);
          reject = ~do_start;
        end
        OPC_SECTOR_ERASE: begin
          st_kind = OPK_SECTOR;
          st_addr = addr & SECTOR_MASK;
          do_start = write_enable_latch & ~is_prot(bp, addr & SECTOR_MASK);
          reject = ~do_start;
        end
        OPC_BLOCK_ERASE: begin
          st_kind = OPK_BLOCK;
          st_addr = addr & BLOCK_MASK;
          do_start = write_enable_latch & ~is_prot(bp, addr & BLOCK_MASK);
          reject = ~do_start;
        end
        OPC_CHIP_ERASE: begin
          st_kind = OPK_CHIP;
          st_addr = ADDR_ZERO;
          do_start = write_enable_latch & (bp == BP_NONE);
          reject = ~do_start;
        end
        OPC_AUTO_INC: begin
          if (auto_increment_program) begin
            st_addr = aai_addr + ADDR_ONE;
            do_start = write_enable_latch & ~is_prot(bp, aai_addr + ADDR_ONE);
          end else begin
            aai_first = write_enable_latch & ~is_prot(bp, addr);
            do_start = aai_first;
          end
          reject = ~do_start;
        end
        default: reject = 1'b0;
      endcase
    end
  end

  // busy timer
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      busy <= 1'b0;
      busy_cnt <= '0;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      if (do_start) begin
        busy <= 1'b1;
        busy_cnt <= busy_load(st_kind);
      end else if (busy) begin
        if (busy_cnt == '0) begin
          busy <= 1'b0;
          op_done <= 1'b1;
        end else begin
          busy_cnt <= busy_cnt - BUSY_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      OP_START <= 1'b0;
      OP_KIND <= OPK_PROGRAM;
      OP_ADDR <= ADDR_ZERO;
      OP_DATA <= 8'h00;
      aai_addr <= ADDR_ZERO;
      op_in_aai <= 1'b0;
      aai_last <= 1'b0;
    end else begin
      OP_START <= do_start;
      if (do_start) begin
        OP_KIND <= st_kind;
        OP_ADDR <= st_addr;
        OP_DATA <= data;
        op_in_aai <= opcode == OPC_AUTO_INC;
        // last unprotected location sits just below the protected base
        aai_last <= {1'b0, st_addr} == prot_base(bp) - 21'h1;
        if (opcode == OPC_AUTO_INC) begin
          aai_addr <= st_addr;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      write_enable_latch <= 1'b0;
    end else if (do_wren) begin
      write_enable_latch <= 1'b1;
    end else if (do_write_disable_cmd || ws_ok) begin
      write_enable_latch <= 1'b0;
    end else if (op_done && (!op_in_aai || aai_last)) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      auto_increment_program <= 1'b0;
    end else if (aai_first) begin
      auto_increment_program <= 1'b1;
    end else if (do_write_disable_cmd || (op_done && op_in_aai && aai_last)) begin
      auto_increment_program <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      bp <= BP_RESET;
      lock <= 1'b0;
    end else if (ws_ok) begin
      bp <= data[STAT_BP_MSB:STAT_BP_LSB];
      lock <= data[STAT_LOCK];
    end
  end

  // bus slave: zero wait states, read data fetched in the address phase
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ahb_wr <= 1'b0;
      ahb_addr <= 8'h00;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (HREADY) begin
        ahb_wr <= HSEL & HTRANS[1] & HWRITE;
        ahb_addr <= HADDR[7:0];
        if (ahb_rd_ok) begin
          case (HADDR[7:0])
            OFS_STATUS: HRDATA <= {23'h0, wp_s2, status};
            OFS_IRQ_STAT: HRDATA <= {29'h0, irq_stat};
            OFS_IRQ_MASK: HRDATA <= {29'h0, irq_mask};
            default: HRDATA <= 32'h00000000;
          endcase
        end
      end
    end
  end

  assign ahb_rd_ok = HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE;
  assign irq_set = {ws_refused, reject, op_done};
  assign irq_clr = (ahb_wr && ahb_addr == OFS_IRQ_STAT) ? HWDATA[IRQ_W-1:0] : '0;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat <= '0;
      irq_mask <= '0;
      IRQ <= 1'b0;
    end else begin
      // a new event outweighs a clear in the same cycle
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (ahb_wr && ahb_addr == OFS_IRQ_MASK) begin
        irq_mask <= HWDATA[IRQ_W-1:0];
      end
      IRQ <= |(irq_stat & irq_mask);
    end
  end
endmodule : flsw_top

// >>> verification/flsw_top_sva.sv
/*
  Port-level checker of flsw_top: bus answer, op launch pulses,
  erase address alignment, busy spacing of launches, serial output release.
  Assumes one clock domain, REF_CLK, reset NRST.
*/
`timescale 1ns/1ps
module flsw_top_chk
  import flsw_pkg::*;
#(
  parameter int PROG_CYCLES = 200
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic SPI_CE_N,
  input wire logic SPI_SO_OE,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic OP_START,
  input wire logic [1:0] OP_KIND,
  input wire logic [flsw_pkg::ADDR_W-1:0] OP_ADDR
);
  logic [31:0] since_start;
  // saturates so that the first launch after reset always passes
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) since_start <= 32'hffffffff;
    else if (OP_START) since_start <= 32'h0;
    else if (since_start != 32'hffffffff) since_start <= since_start + 32'h1;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  sequence s_ce_rise;
    $rose(SPI_CE_N);
  endsequence
  sequence s_start;
    OP_START;
  endsequence
  chk_ready_high: assert property (HREADYOUT) else $error("hreadyout low");
  chk_resp_okay: assert property (!HRESP) else $error("hresp not okay");
  chk_start_pulse: assert property (s_start |=> !OP_START) else $error("start too long");
  chk_busy_gap: assert property (s_start |-> since_start >= PROG_CYCLES)
    else $error("launch while busy");
  chk_sector_base: assert property (OP_START && OP_KIND == OPK_SECTOR
    |-> (OP_ADDR & ~SECTOR_MASK) == ADDR_ZERO) else $error("sector base");
  chk_block_base: assert property (OP_START && OP_KIND == OPK_BLOCK
    |-> (OP_ADDR & ~BLOCK_MASK) == ADDR_ZERO) else $error("block base");
  chk_chip_addr: assert property (OP_START && OP_KIND == OPK_CHIP
    |-> OP_ADDR == ADDR_ZERO) else $error("chip address");
  chk_so_release: assert property (s_ce_rise |-> ##[1:8] !SPI_SO_OE) else $error("so held");
endmodule : flsw_top_chk

bind flsw_top flsw_top_chk #(.PROG_CYCLES(PROG_CYCLES)) flsw_top_chk_inst (
  .REF_CLK(REF_CLK),
  .NRST(NRST),
  .SPI_CE_N(SPI_CE_N),
  .SPI_SO_OE(SPI_SO_OE),
  .HREADYOUT(HREADYOUT),
  .HRESP(HRESP),
  .OP_START(OP_START),
  .OP_KIND(OP_KIND),
  .OP_ADDR(OP_ADDR)
);

// >>> verification/flsw_spi_host.sv
/*
  Serial host model, mode 0: one whole command per chip-select frame.
  Assumes the 400 ns serial clock is free of REF_CLK phase.
*/
`timescale 1ns/1ps
module flsw_spi_host (
  output logic ce_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  initial begin
    ce_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // rx returns the last eight bits seen on so
  task automatic frame(input logic [7:0] tx [$], output logic [7:0] rx);
    #13 ce_n = 1'b0;
    foreach (tx[b]) begin
      for (int i = 7; i >= 0; i--) begin
        si = tx[b][i];
        #200 sck = 1'b1;
        rx = {rx[6:0], so};
        #200 sck = 1'b0;
      end
    end
    #200 ce_n = 1'b1;
    // released line must not keep the last bit
    si = ~si;
    #600;
  endtask : frame
endmodule : flsw_spi_host

// >>> verification/flsw_top_tb.sv
/*
  Self-checking bench of flsw_top: serial host model, AHB-Lite master tasks.
  Assumes busy counts set at the instance: erase counts shortened, program count doubled.
*/
`timescale 1ns/1ps
module flsw_top_tb;
  import flsw_pkg::*;
  logic ref_clk, nrst, wp_n, hsel, hwrite, ce_n, sck, si, so, so_oe, hreadyout, hresp, irq;
  logic op_start;
  logic [1:0] htrans, op_kind, s_kind;
  logic [31:0] haddr, hwdata, hrdata;
  logic [ADDR_W-1:0] op_addr, s_addr;
  logic [7:0] op_data, s_data, rx;
  int fails, total_checks, n_starts, n0;
  flsw_spi_host flsw_spi_host_inst (.ce_n(ce_n), .sck(sck), .si(si), .so(so));
  // program long enough for a serial status poll and one ignored command
  flsw_top #(.PROG_CYCLES(400), .SECTOR_CYCLES(400), .BLOCK_CYCLES(400), .CHIP_CYCLES(600))
  flsw_top_inst (.REF_CLK(ref_clk), .NRST(nrst), .SPI_CE_N(ce_n), .SPI_SCK(sck),
    .SPI_SI(si), .SPI_SO(so), .SPI_SO_OE(so_oe), .WP_N(wp_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .IRQ(irq), .OP_START(op_start), .OP_KIND(op_kind), .OP_ADDR(op_addr),
    .OP_DATA(op_data));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (op_start === 1'b1) begin
      n_starts++;
      s_kind = op_kind;
      s_addr = op_addr;
      s_data = op_data;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, ofs, d, x);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, ofs, 32'h0, d);
    chk(name, exp, d);
  endtask : rd_chk
  function automatic logic [31:0] st(input logic [7:0] s);
    return {23'h0, wp_n, s};
  endfunction : st
  task automatic spi(input logic [7:0] tx [$]);
    flsw_spi_host_inst.frame(tx, rx);
  endtask : spi
  task automatic wait_ready;
    logic [31:0] d;
    d = 32'h1;
    for (int i = 0; i < 2000 && d[0] !== 1'b0; i++) ahb(1'b0, OFS_STATUS, 32'h0, d);
    chk("busy", 32'h0, {31'h0, d[0]});
  endtask : wait_ready
  task automatic t_reset;
    rd_chk("status", OFS_STATUS, st(8'h1c));
    rd_chk("irq_mask", OFS_IRQ_MASK, 32'h0);
    rd_chk("unmapped", 8'h0c, 32'h0);
    spi('{OPC_READ_STATUS, 8'h00});
    chk("spi_status", 32'h1c, {24'h0, rx});
    n0 = n_starts;
    spi('{OPC_BYTE_PROG, 8'h00, 8'h01, 8'h00, 8'h5a});
    chk("starts", n0, n_starts);
    rd_chk("irq_stat", OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_STAT, 32'h7);
    rd_chk("irq_stat", OFS_IRQ_STAT, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_prog;
    spi('{OPC_WRITE_STATUS, 8'h00});
    rd_chk("status", OFS_STATUS, st(8'h00));
    spi('{OPC_WRITE_ENABLE});
    rd_chk("status", OFS_STATUS, st(8'h02));
    spi('{OPC_WRITE_DISABLE});
    rd_chk("status", OFS_STATUS, st(8'h00));
    spi('{OPC_WRITE_ENABLE});
    wr(OFS_IRQ_MASK, 32'h1);
    spi('{OPC_BYTE_PROG, 8'h01, 8'h23, 8'h45, 8'ha5});
    rd_chk("status", OFS_STATUS, st(8'h03));
    chk("addr", 32'h12345, 32'(s_addr));
    chk("data", 32'ha5, 32'(s_data));
    chk("kind", 32'(OPK_PROGRAM), 32'(s_kind));
    spi('{OPC_READ_STATUS, 8'h00});
    chk("spi_status", 32'h03, {24'h0, rx});
    // a disable that acted would drop the latch while still busy
    spi('{OPC_WRITE_DISABLE});
    rd_chk("status", OFS_STATUS, st(8'h03));
    wait_ready;
    rd_chk("status", OFS_STATUS, st(8'h00));
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h7);
    rd_chk("irq_stat", OFS_IRQ_STAT, 32'h0);
    $display("t_prog done");
  endtask : t_prog
  task automatic t_lock;
    @(posedge ref_clk) wp_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    spi('{OPC_WRITE_STATUS, 8'h84});
    rd_chk("status", OFS_STATUS, st(8'h84));
    spi('{OPC_WRITE_ENABLE});
    spi('{OPC_WRITE_STATUS, 8'h00});
    rd_chk("status", OFS_STATUS, st(8'h86));
    rd_chk("irq_stat", OFS_IRQ_STAT, 32'h4);
    @(posedge ref_clk) wp_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    spi('{OPC_WRITE_STATUS, 8'h04});
    rd_chk("status", OFS_STATUS, st(8'h04));
    $display("t_lock done");
  endtask : t_lock
  task automatic t_protect;
    logic [7:0] opc [3] = '{OPC_SECTOR_ERASE, OPC_BLOCK_ERASE, OPC_CHIP_ERASE};
    logic [19:0] base [3] = '{20'h12000, 20'h10000, 20'h00000};
    n0 = n_starts;
    spi('{OPC_WRITE_ENABLE});
    spi('{OPC_BYTE_PROG, 8'h0f, 8'h00, 8'h00, 8'h11});
    spi('{OPC_WRITE_ENABLE});
    spi('{OPC_CHIP_ERASE});
    spi('{OPC_WRITE_STATUS, 8'h20});
    spi('{OPC_WRITE_ENABLE});
    spi('{OPC_CHIP_ERASE});
    chk("starts", n0, n_starts);
    spi('{OPC_WRITE_ENABLE});
    spi('{OPC_BYTE_PROG, 8'h0f, 8'hff, 8'hff, 8'h33});
    chk("addr", 32'hfffff, 32'(s_addr));
    wait_ready;
    spi('{OPC_WRITE_STATUS, 8'h00});
    for (int k = 0; k < 3; k++) begin
      spi('{OPC_WRITE_ENABLE});
      n0 = n_starts;
      if (k == 2) spi('{opc[k]});
      else spi('{opc[k], 8'h01, 8'h23, 8'h45});
      chk("starts", n0 + 1, n_starts);
      chk("kind", k + 1, 32'(s_kind));
      chk("addr", 32'(base[k]), 32'(s_addr));
      wait_ready;
      rd_chk("status", OFS_STATUS, st(8'h00));
    end
    $display("t_protect done");
  endtask : t_protect
  task automatic t_auto;
    spi('{OPC_WRITE_STATUS, 8'h04});
    spi('{OPC_WRITE_ENABLE});
    spi('{OPC_AUTO_INC, 8'h0e, 8'hff, 8'hfe, 8'h11});
    chk("addr", 32'hefffe, 32'(s_addr));
    wait_ready;
    rd_chk("status", OFS_STATUS, st(8'h46));
    spi('{OPC_AUTO_INC, 8'h22});
    chk("addr", 32'heffff, 32'(s_addr));
    chk("data", 32'h22, 32'(s_data));
    wait_ready;
    rd_chk("status", OFS_STATUS, st(8'h04));
    $display("t_auto done");
  endtask : t_auto
  task automatic t_rerst;
    spi('{OPC_WRITE_STATUS, 8'h80});
    rd_chk("status", OFS_STATUS, st(8'h80));
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk("status", OFS_STATUS, st(8'h1c));
    $display("t_rerst done");
  endtask : t_rerst
  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset;
    t_prog;
    t_lock;
    t_protect;
    t_auto;
    t_rerst;
    report_and_stop;
  end
  initial begin
    #2000000;
    fails++;
    report_and_stop;
  end
endmodule : flsw_top_tb
